// File: verilog/acs_regs.sv
// serial-port register bank for calibration sources, clock mode and core standby
//
// How it works
// RQ1 - channel select steers master, all or one
// RQ2 - calibration-set register picks factory set
// RQ3 - read-only offsets show selected factory set
// RQ4 - source bit 0 applies user offsets
// RQ5 - source 0101 adds user trims one-seven
// RQ6 - 0181 adds gain, 01C1 adds internal gain
// RQ7 - 1D1 adds phase; earlier groups stay user
// RQ8 - host addresses cores singly, switches all
// RQ9 - clock mode bit 0 picks stagger/simultaneous
// RQ10 - clock mode bit 1 halves core clock
// RQ11 - stagger: four cores, or pair AB/CD
// RQ12 - simultaneous: all powered cores share phase
// RQ13 - per-core standby bit, zero keeps powered
// RQ14 - standby bit one powers core down
// RQ15 - calibration-set address decoded in every space
// RQ16 - all-channel write updates every core copy
// RQ17 - single-channel read returns that core copy
`timescale 1ns/1ps
`default_nettype none
module acs_regs
  import acs_pkg::*;
(
  input wire logic clock,
  input wire logic rst,
  input wire acs_spi_in_t spi_in,
  output logic spi_miso,
  output logic spi_miso_oe,
  input wire acs_cal_t factory_set0,
  input wire acs_cal_t factory_set1,
  output acs_cal_t applied_cal,
  output logic [3:0] core_power_down,
  output logic [3:0][1:0] core_phase,
  output logic core_clock_enable,
  output logic stagger_fault
);

  typedef struct packed {
    logic [2:0] sclk_s;
    logic [1:0] csn_s;
    logic [1:0] mosi_s;
    logic [4:0] cnt;
    logic [24:0] shin;
    logic [15:0] shout;
    logic rw;
    logic [7:0] addr;
    logic miso;
    logic miso_oe;
    logic [2:0] chan_sel;
    logic cal_set;
    logic [15:0] src_sel;
    logic [1:0] clk_mode;
    acs_cal_t user;
    logic [3:0] power_down;
    acs_cal_t applied;
    logic [3:0][1:0] phase;
    logic fault;
    logic clk_en;
  } acs_state_t;

  acs_state_t s;
  acs_state_t next_s;

  // register read mux for the current address space
  function automatic logic [15:0] acs_read(input acs_state_t st, input acs_cal_t fac,
                                            input logic [7:0] a);
    logic [15:0] d;
    logic [1:0] ch;
    d = 16'h0000;
    ch = (st.chan_sel == SEL_ALL) ? 2'h0 : st.chan_sel[1:0]; // RQ17
    if (a == ADDR_CHAN_SEL) begin
      d = {13'h0000, st.chan_sel};
    end else if (a == ADDR_CAL_SET) begin
      d = {15'h0000, st.cal_set}; // RQ15
    end else if (a == ADDR_SRC_SEL) begin
      d = st.src_sel;
    end else if (st.chan_sel == SEL_MASTER) begin
      if (a == ADDR_CLK_MODE) begin
        d = {14'h0000, st.clk_mode};
      end
      for (int i = 0; i < NCORE; i++) begin
        if (a == ADDR_OFFSET_RW + 8'(i)) d = {7'h00, st.user.offset[i]};
        if (a == ADDR_OFFSET_RO + 8'(i)) d = {7'h00, fac.offset[i]}; // RQ3
      end
    end else if (st.chan_sel <= SEL_ALL) begin
      for (int t = 0; t < NTRIM; t++) begin
        if (a == ADDR_TRIM_RW + 8'(t)) d = {9'h000, st.user.trim[ch][t]};
        if (a == ADDR_TRIM_RO + 8'(t)) d = {9'h000, fac.trim[ch][t]};
      end
      if (a == ADDR_GAIN_RW) d = {6'h00, st.user.gain[ch]};
      if (a == ADDR_GAIN_RO) d = {6'h00, fac.gain[ch]};
      if (a == ADDR_IGAIN_RW) d = {8'h00, st.user.igain[ch]};
      if (a == ADDR_IGAIN_RO) d = {8'h00, fac.igain[ch]};
      if (a == ADDR_PHASE_RW) d = {8'h00, st.user.phase[ch]};
      if (a == ADDR_PHASE_RO) d = {8'h00, fac.phase[ch]};
      if (a == ADDR_POWER_DOWN) d = {15'h0000, st.power_down[ch]};
    end
    return d;
  endfunction : acs_read

  // next state: serial framing, register writes, setting selection, clock plan
  always_comb begin
    acs_cal_t fac;
    logic [24:0] nb;
    logic [3:0] on;
    logic hit;
    hit = 1'b0;
    on = 4'h0;
    next_s = s;
    fac = s.cal_set ? factory_set1 : factory_set0; // RQ2
    nb = {s.shin[23:0], s.mosi_s[1]};
    next_s.sclk_s = {s.sclk_s[1:0], spi_in.sclk};
    next_s.csn_s = {s.csn_s[0], spi_in.csn};
    next_s.mosi_s = {s.mosi_s[0], spi_in.mosi};
    if (s.csn_s[1]) begin
      next_s.cnt = 5'd0;
      next_s.rw = 1'b0;
      next_s.miso = 1'b0;
    end else if (s.sclk_s[1] && !s.sclk_s[2]) begin
      // rising serial clock: shift in one bit
      next_s.shin = nb;
      if (s.cnt != FRAME_BITS) next_s.cnt = s.cnt + 5'd1;
      if (s.cnt == FRAME_HDR_BITS - 5'd1) begin
        next_s.rw = nb[8];
        next_s.addr = nb[7:0];
        next_s.shout = acs_read(s, fac, nb[7:0]);
      end
      if (s.cnt == FRAME_BITS - 5'd1 && !s.rw) begin
        // write commit on the last data bit
        if (s.addr == ADDR_CHAN_SEL) next_s.chan_sel = nb[2:0]; // RQ1
        if (s.addr == ADDR_CAL_SET) next_s.cal_set = nb[0]; // RQ15
        if (s.addr == ADDR_SRC_SEL) next_s.src_sel = nb[15:0]; // RQ8
        if (s.chan_sel == SEL_MASTER) begin
          if (s.addr == ADDR_CLK_MODE) next_s.clk_mode = nb[1:0];
          for (int i = 0; i < NCORE; i++) begin
            if (s.addr == ADDR_OFFSET_RW + 8'(i)) next_s.user.offset[i] = nb[8:0];
          end
        end
        for (int c = 0; c < NCORE; c++) begin
          hit = (s.chan_sel == SEL_ALL) || (s.chan_sel == 3'(c)); // RQ16
          if (hit) begin
            for (int t = 0; t < NTRIM; t++) begin
              if (s.addr == ADDR_TRIM_RW + 8'(t)) next_s.user.trim[c][t] = nb[6:0];
            end
            if (s.addr == ADDR_GAIN_RW) next_s.user.gain[c] = nb[9:0];
            if (s.addr == ADDR_IGAIN_RW) next_s.user.igain[c] = nb[7:0];
            if (s.addr == ADDR_PHASE_RW) next_s.user.phase[c] = nb[7:0];
            if (s.addr == ADDR_POWER_DOWN) next_s.power_down[c] = nb[0]; // RQ13 RQ14
          end
        end
      end
    end else if (!s.sclk_s[1] && s.sclk_s[2] && s.rw && s.cnt >= FRAME_HDR_BITS) begin
      // falling serial clock: present next read bit
      next_s.miso = s.shout[15];
      next_s.shout = {s.shout[14:0], 1'b0};
    end
    next_s.miso_oe = !s.csn_s[1] && s.rw && (s.cnt >= FRAME_HDR_BITS);
    // pick user or factory value for each group
    next_s.applied = fac;
    if (s.src_sel[SRC_OFFSET_BIT]) next_s.applied.offset = s.user.offset; // RQ4
    if (s.src_sel[SRC_TRIM_BIT]) next_s.applied.trim = s.user.trim; // RQ5
    if (s.src_sel[SRC_GAIN_BIT]) next_s.applied.gain = s.user.gain; // RQ6
    if (s.src_sel[SRC_IGAIN_BIT]) next_s.applied.igain = s.user.igain; // RQ6
    if (s.src_sel[SRC_PHASE_BIT]) next_s.applied.phase = s.user.phase; // RQ7
    // core sampling phase in quarter periods
    on = ~s.power_down;
    next_s.fault = 1'b0;
    for (int c = 0; c < NCORE; c++) begin
      next_s.phase[c] = 2'h0; // RQ12
    end
    if (s.clk_mode[CLK_STAGGER_BIT]) begin
      if (on == 4'b1111) begin
        for (int c = 0; c < NCORE; c++) begin
          next_s.phase[c] = 2'(c); // RQ9
        end
      end else if (on == 4'b0011) begin
        next_s.phase[1] = 2'h2; // RQ11
      end else if (on == 4'b1100) begin
        next_s.phase[3] = 2'h2; // RQ11
      end else begin
        next_s.fault = 1'b1; // RQ11
      end
    end
    // halving: cores run on every other input clock
    next_s.clk_en = s.clk_mode[CLK_HALVING_BIT] ? !s.clk_en : 1'b1; // RQ10
  end

  // state register
  always_ff @(posedge clock) begin
    if (rst) begin
      s <= '0;
      s.sclk_s <= 3'h0;
      s.csn_s <= 2'h3;
      s.chan_sel <= RST_CHAN_SEL;
      s.clk_mode <= RST_CLK_MODE;
      s.clk_en <= 1'b1;
      for (int c = 0; c < NCORE; c++) begin
        s.user.offset[c] <= RST_OFFSET;
        s.user.gain[c] <= RST_GAIN;
        s.user.igain[c] <= RST_IGAIN;
        s.user.phase[c] <= RST_PHASE;
        for (int t = 0; t < NTRIM; t++) begin
          s.user.trim[c][t] <= RST_TRIM;
        end
      end
    end else begin
      s <= next_s;
    end
  end

  // outputs straight from the state flops
  assign spi_miso = s.miso;
  assign spi_miso_oe = s.miso_oe;
  assign applied_cal = s.applied;
  assign core_power_down = s.power_down;
  assign core_phase = s.phase;
  assign core_clock_enable = s.clk_en;
  assign stagger_fault = s.fault;
endmodule : acs_regs
`default_nettype wire

// File: verilog/acs_pkg.sv
// shared constants and carrier types of the calibration and clock mode register bank
`default_nettype none
package acs_pkg;
  localparam int NCORE = 4;
  localparam int NTRIM = 7;
  // register addresses
  localparam logic [7:0] ADDR_CHAN_SEL = 8'h01;
  localparam logic [7:0] ADDR_CLK_MODE = 8'h07;
  localparam logic [7:0] ADDR_CAL_SET = 8'h15;
  localparam logic [7:0] ADDR_SRC_SEL = 8'h16;
  localparam logic [7:0] ADDR_OFFSET_RW = 8'h17;
  localparam logic [7:0] ADDR_OFFSET_RO = 8'h6B;
  localparam logic [7:0] ADDR_TRIM_RW = 8'h33;
  localparam logic [7:0] ADDR_TRIM_RO = 8'h4F;
  localparam logic [7:0] ADDR_GAIN_RW = 8'h3A;
  localparam logic [7:0] ADDR_GAIN_RO = 8'h56;
  localparam logic [7:0] ADDR_IGAIN_RW = 8'h3B;
  localparam logic [7:0] ADDR_IGAIN_RO = 8'h57;
  localparam logic [7:0] ADDR_PHASE_RW = 8'h3D;
  localparam logic [7:0] ADDR_PHASE_RO = 8'h59;
  localparam logic [7:0] ADDR_POWER_DOWN = 8'hFC;
  // channel select codes
  localparam logic [2:0] SEL_ALL = 3'h4;
  localparam logic [2:0] SEL_MASTER = 3'h7;
  // source select field positions
  localparam int SRC_OFFSET_BIT = 0;
  localparam int SRC_PHASE_BIT = 4;
  localparam int SRC_IGAIN_BIT = 6;
  localparam int SRC_GAIN_BIT = 7;
  localparam int SRC_TRIM_BIT = 8;
  // clock mode field positions
  localparam int CLK_STAGGER_BIT = 0;
  localparam int CLK_HALVING_BIT = 1;
  // reset values
  localparam logic [2:0] RST_CHAN_SEL = 3'h7;
  localparam logic [1:0] RST_CLK_MODE = 2'h1;
  localparam logic [8:0] RST_OFFSET = 9'h100;
  localparam logic [6:0] RST_TRIM = 7'h40;
  localparam logic [9:0] RST_GAIN = 10'h200;
  localparam logic [7:0] RST_IGAIN = 8'h80;
  localparam logic [7:0] RST_PHASE = 8'h80;
  // serial frame: read flag, 8 address bits, 16 data bits
  localparam logic [4:0] FRAME_HDR_BITS = 5'd9;
  localparam logic [4:0] FRAME_BITS = 5'd25;

  // one full calibration set for the four cores
  typedef struct packed {
    logic [3:0][8:0] offset;
    logic [3:0][6:0][6:0] trim;
    logic [3:0][9:0] gain;
    logic [3:0][7:0] igain;
    logic [3:0][7:0] phase;
  } acs_cal_t;

  // serial port pins as seen by the device
  typedef struct packed {
    logic sclk;
    logic csn;
    logic mosi;
  } acs_spi_in_t;
endpackage : acs_pkg
`default_nettype wire

// File: tb/acs_regs_sva.sv
// assertion checker watching the register bank ports
`timescale 1ns/1ps
`default_nettype none
module acs_regs_chk
  import acs_pkg::*;
(
  input wire logic clock,
  input wire logic rst,
  input wire acs_spi_in_t spi_in,
  input wire logic spi_miso,
  input wire logic spi_miso_oe,
  input wire acs_cal_t applied_cal,
  input wire logic [3:0] core_power_down,
  input wire logic [3:0][1:0] core_phase,
  input wire logic core_clock_enable,
  input wire logic stagger_fault
);
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (rst);
  // read line and its enable only inside frames
  property p_miso_idle; !spi_miso_oe |-> !spi_miso; endproperty
  a_miso_idle: assert property (p_miso_idle) else $error("miso set undriven");
  property p_oe_frame; spi_miso_oe |-> !$past(spi_in.csn, 5); endproperty
  a_oe_frame: assert property (p_oe_frame) else $error("oe outside frame");
  property p_oe_off; spi_in.csn [*8] |-> !spi_miso_oe; endproperty
  a_oe_off: assert property (p_oe_off) else $error("oe held idle");
  // settings move only through frames
  property p_quiet; spi_in.csn [*8] |-> $stable(applied_cal) && $stable(core_phase)
    && $stable(core_power_down); endproperty
  a_quiet: assert property (p_quiet) else $error("settings moved idle");
  // clock halving and phase plan
  property p_halve; !core_clock_enable |=> core_clock_enable; endproperty
  a_halve: assert property (p_halve) else $error("enable low twice");
  property p_stag4; core_power_down == 4'h0 && $stable(core_power_down) && core_phase[1] != 2'h0
    |-> core_phase == 8'hE4; endproperty
  a_stag4: assert property (p_stag4) else $error("quarter phases wrong");
  property p_pair; core_power_down == 4'hC && $stable(core_power_down) && core_phase[1] != 2'h0
    |-> core_phase[1] == 2'h2; endproperty
  a_pair: assert property (p_pair) else $error("pair phase wrong");
  property p_fault; stagger_fault && $stable(core_power_down)
    |-> !(core_power_down inside {4'h0, 4'h3, 4'hC}); endproperty
  a_fault: assert property (p_fault) else $error("fault on legal set");
endmodule : acs_regs_chk
`default_nettype wire

// File: tb/acs_host.sv
// serial configuration host model driving register frames
`timescale 1ns/1ps
`default_nettype none
module acs_host
  import acs_pkg::*;
(
  input wire logic clock,
  input wire logic miso,
  output var acs_spi_in_t spi
);
  // frame select idle high, serial clock parked low
  initial spi = '{sclk: 1'b0, csn: 1'b1, mosi: 1'b0};
  // one 25-bit frame, six device clocks per serial phase
  task automatic xfer(input logic rd, input logic [7:0] a, input logic [15:0] d,
    output logic [15:0] q);
    logic [24:0] f;
    f = {rd, a, d};
    spi.csn = 1'b0;
    for (int i = 24; i >= 0; i--) begin
      spi.mosi = f[i];
      repeat (6) @(negedge clock);
      if (i < 16) q[i] = miso;
      spi.sclk = 1'b1;
      repeat (6) @(negedge clock);
      spi.sclk = 1'b0;
    end
    repeat (6) @(negedge clock);
    spi.csn = 1'b1;
    spi.mosi = ~spi.mosi; // released line shows no stale bit
    repeat (8) @(negedge clock);
  endtask : xfer
endmodule : acs_host
`default_nettype wire

// File: tb/tb_top.sv
// top testbench for the calibration and clock mode register bank
`timescale 1ns/1ps
`default_nettype none
module tb_top
  import acs_pkg::*;
;
  logic clock = 1'b0;
  logic rst = 1'b1;
  acs_spi_in_t spi_in;
  logic spi_miso, spi_miso_oe, core_clock_enable, stagger_fault;
  acs_cal_t f0, f1, applied_cal;
  logic [3:0] core_power_down;
  logic [3:0][1:0] core_phase;
  logic [15:0] q;
  logic [8:0] uo [4];
  logic [6:0] ut [7];
  logic [9:0] ug [4];
  logic [15:0] src [4] = '{16'h0101, 16'h0181, 16'h01C1, 16'h01D1};
  int n_fail = 0;
  int checks_done = 0;
  always #5 clock = ~clock;
  acs_regs u_dut (.clock, .rst, .spi_in, .spi_miso, .spi_miso_oe, .factory_set0(f0),
    .factory_set1(f1), .applied_cal, .core_power_down, .core_phase, .core_clock_enable,
    .stagger_fault);
  acs_host u_host (.clock, .miso(spi_miso), .spi(spi_in));
  task automatic chk(input string n, input logic [335:0] e, input logic [335:0] s);
    checks_done++;
    if (s !== e) begin
      n_fail++;
      $display("ERROR %s exp %0h got %0h", n, e, s);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    u_host.xfer(1'b0, a, d, q);
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [15:0] e, input string n);
    u_host.xfer(1'b1, a, 16'h0000, q);
    chk(n, 336'(e), 336'(q));
  endtask : rd
  // expected sampling phases per powered set and mode
  function automatic logic [7:0] exp_phase(input logic [3:0] pd, input logic stag);
    if (!stag) return 8'h00;
    if (pd == 4'hC) return 8'h08;
    return 8'hE4;
  endfunction : exp_phase
  task automatic finish_test;
    if (n_fail == 0 && checks_done > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : finish_test
  // watchdog sized well past the planned frames
  initial begin
    #400us;
    n_fail++;
    finish_test();
  end
  // main sequence
  initial begin
    void'($urandom(77));
    for (int i = 0; i < $bits(acs_cal_t); i++) begin
      f0[i] = 1'($urandom);
      f1[i] = 1'($urandom);
    end
    repeat (8) @(negedge clock);
    rst = 1'b0;
    repeat (4) @(negedge clock);
    chk("applied", f0, applied_cal);
    chk("phase", exp_phase(4'h0, 1'b1), core_phase);
    chk("pd", 4'h0, core_power_down);
    rd(ADDR_CLK_MODE, 16'h0001, "clk_mode");
    for (int s = 0; s < 2; s++) begin
      wr(ADDR_CAL_SET, 16'(s));
      for (int c = 0; c < 4; c++) begin
        rd(ADDR_OFFSET_RO + 8'(c), s ? f1.offset[c] : f0.offset[c], "ro");
      end
    end
    chk("applied", f1, applied_cal);
    for (int c = 0; c < 4; c++) begin
      uo[c] = c ? 9'($urandom) : 9'h1FF;
      wr(ADDR_OFFSET_RW + 8'(c), 16'(uo[c]));
    end
    wr(ADDR_SRC_SEL, 16'h0001);
    for (int c = 0; c < 4; c++) chk("off", uo[c], applied_cal.offset[c]);
    wr(ADDR_CHAN_SEL, 16'(SEL_ALL));
    for (int t = 0; t < 7; t++) begin
      ut[t] = 7'($urandom);
      wr(ADDR_TRIM_RW + 8'(t), 16'(ut[t]));
    end
    for (int c = 0; c < 4; c++) begin
      ug[c] = 10'($urandom);
      wr(ADDR_CHAN_SEL, 16'(c));
      wr(ADDR_GAIN_RW, 16'(ug[c]));
      rd(ADDR_TRIM_RW + 8'(c), 16'(ut[c]), "trim");
      rd(ADDR_GAIN_RW, 16'(ug[c]), "gain");
    end
    wr(ADDR_CAL_SET, 16'h0000);
    chk("cal_ch", f0.gain, applied_cal.gain);
    wr(ADDR_CHAN_SEL, 16'(SEL_ALL));
    foreach (src[k]) begin
      wr(ADDR_SRC_SEL, src[k]);
      for (int c = 0; c < 4; c++) begin
        chk("trim", ut[6], applied_cal.trim[c][6]);
        chk("off", uo[c], applied_cal.offset[c]);
        chk("gain", k > 0 ? ug[c] : f0.gain[c], applied_cal.gain[c]);
        chk("igain", k > 1 ? RST_IGAIN : f0.igain[c], applied_cal.igain[c]);
        chk("phase", k > 2 ? RST_PHASE : f0.phase[c], applied_cal.phase[c]);
      end
    end
    wr(ADDR_CHAN_SEL, 16'(SEL_MASTER));
    wr(ADDR_CLK_MODE, 16'h0000);
    chk("sim", exp_phase(4'h0, 1'b0), core_phase);
    wr(ADDR_CLK_MODE, 16'h0003);
    q[0] = core_clock_enable;
    @(negedge clock);
    chk("halve", 1'b1, q[0] ^ core_clock_enable);
    for (int c = 1; c < 4; c++) begin
      wr(ADDR_CHAN_SEL, 16'(4 - c));
      wr(ADDR_POWER_DOWN, 16'h0001);
      if (c == 2) chk("pair", exp_phase(4'hC, 1'b1), core_phase);
      chk("fault", c != 2, stagger_fault);
    end
    chk("pd", 4'hE, core_power_down);
    rd(ADDR_POWER_DOWN, 16'h0001, "pd_b");
    wr(ADDR_CHAN_SEL, 16'h0000);
    rd(ADDR_POWER_DOWN, 16'h0000, "pd_a");
    rd(8'h80, 16'h0000, "unmapped");
    finish_test();
  end
endmodule : tb_top
bind acs_regs acs_regs_chk u_chk (.clock, .rst, .spi_in, .spi_miso, .spi_miso_oe, .applied_cal,
  .core_power_down, .core_phase, .core_clock_enable, .stagger_fault);
`default_nettype wire
